//--- ovs_cfg.svh
`ifndef OVS_CFG_SVH
`define OVS_CFG_SVH

// register byte offsets
`define OVS_ADDR_W          8
`define OVS_OFS_CFG         8'h00
`define OVS_OFS_LEVEL       8'h04
`define OVS_OFS_DWELL       8'h08
`define OVS_OFS_BRK_REL     8'h0c
`define OVS_OFS_BRK_ENG     8'h10
`define OVS_OFS_STATUS      8'h14

// field positions
`define OVS_CFG_LOAD_BIT    0
`define OVS_CFG_MODE_LSB    2
`define OVS_CFG_QUAL_LSB    4
`define OVS_CFG_ALT_BIT     6
`define OVS_REL_CUR_LSB     0
`define OVS_REL_FRQ_LSB     8
`define OVS_REL_TMR_LSB     16
`define OVS_ENG_FRQ_LSB     0
`define OVS_ENG_TMR_LSB     8

// reset values
`define OVS_CFG_RST         7'h00
`define OVS_LEVEL_RST       16'h0096
`define OVS_DWELL_RST       16'h0000
`define OVS_REL_CUR_RST     8'h00
`define OVS_REL_FRQ_RST     8'h00
`define OVS_ENG_FRQ_RST     8'h00
`define OVS_TMR_RST         9'h000

// setting limits: percent, 0.1 Hz, 10 ms ticks
`define OVS_CUR_MAX         8'hc8
`define OVS_FREQ_MAX        8'hfa
`define OVS_TIMER_MAX       9'h1f4

// timing
`define OVS_CLK_PERIOD_NS   20
`define OVS_TICK_MS         10
`define OVS_TICK_CYCLES     (`OVS_TICK_MS * 1000000 / `OVS_CLK_PERIOD_NS)

`endif

//--- ovs_pkg.sv
package ovs_pkg;

  // stop action on overload
  typedef enum logic [1:0] {
    OVS_MODE_OFF   = 2'b00,
    OVS_MODE_DECEL = 2'b01,
    OVS_MODE_COAST = 2'b10,
    OVS_MODE_HIT   = 2'b11
  } ovs_mode_t;

  // operating states that qualify detection
  typedef enum logic [1:0] {
    OVS_QUAL_CONST_DEC = 2'b00,
    OVS_QUAL_CONST     = 2'b01,
    OVS_QUAL_ALL       = 2'b10,
    OVS_QUAL_NONE      = 2'b11
  } ovs_qual_t;

  // brake command state
  typedef enum logic {
    OVS_BRK_ENGAGED  = 1'b0,
    OVS_BRK_RELEASED = 1'b1
  } ovs_brk_state_t;

endpackage : ovs_pkg

//--- ovs_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "ovs_cfg.svh"

interface ovs_reg_if;
  logic                   wrStb;
  logic [`OVS_ADDR_W-1:0] wrAddr;
  logic [31:0]            wrData;
  logic [`OVS_ADDR_W-1:0] rdAddr;
  logic [31:0]            rdData;

  modport bus (output wrStb, output wrAddr, output wrData, output rdAddr, input rdData);
  modport core (input wrStb, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : ovs_reg_if

`default_nettype wire

//--- ovs_dwell_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ovs_dwell_timer (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        cond,
  input  wire logic [15:0] preset,
  output logic             done
);

  logic [15:0] cnt_r;

  // count ticks while qualified, restart from zero on any dropout
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      cnt_r <= 16'h0000;
    else if (!cond)
      cnt_r <= 16'h0000;
    else if (tick && cnt_r != 16'hffff)
      cnt_r <= cnt_r + 16'h0001;
  end

  // elapsed once the count reaches the preset
  assign done = cond && (cnt_r >= preset);

endmodule : ovs_dwell_timer

`default_nettype wire

//--- ovs_ahb_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "ovs_cfg.svh"

module ovs_ahb_slave (
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  input  wire logic   hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic   hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic   hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  ovs_reg_if.bus      regs
);

  logic                   wrPend_r;
  logic [`OVS_ADDR_W-1:0] wrAddr_r;
  logic                   addrPhase;

  // valid transfer in the address phase; word transfers only
  assign addrPhase = hsel && htrans[1] && hready && (hsize == 3'b010);

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // capture write address, commit in the data phase
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
    end
    else
    begin
      wrPend_r <= addrPhase && hwrite;
      wrAddr_r <= haddr[`OVS_ADDR_W-1:0];
    end
  end

  assign regs.wrStb  = wrPend_r;
  assign regs.wrAddr = wrAddr_r;
  assign regs.wrData = hwdata;
  assign regs.rdAddr = haddr[`OVS_ADDR_W-1:0];

  // read data registered at the address phase
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (addrPhase && !hwrite)
      hrdata <= regs.rdData;
  end

endmodule : ovs_ahb_slave

`default_nettype wire

//--- ovs_overload_brake.sv
// Contract
// - stop triggers when load index stays above level for the dwell time
// - selector 0 watches driving torque, 1 watches output current
// - level is percent of inverter rated current or motor rated torque
// - hit-and-stop mode always compares against motor rated torque
// - mode 0 never triggers the stop
// - mode 1 ramps down with the configured deceleration time
// - mode 2 cuts the output at once, motor coasts
// - mode 3 torque-limited decel, then holds torque until run goes off
// - hit-and-stop raises one of the two overload alarms
// - stop latches; cleared only by run off then on again
// - mode 3 disregards the configured driving torque limit
// - qualifier 0 const or decel, 1 const only, 2 all states
// - dwell timer applies only in modes 1 and 2
// - mode 3 bypasses the dwell timer and acts at once
// - brake release after current and frequency exceed thresholds for timer
// - release current threshold 0 to 200 percent of rated current
// - brake engage after run off and frequency below threshold for timer
// - brake control only for motor 1; motor 2 keeps brake engaged
// - alarm or coast-stop shutdown engages brake immediately
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ovs_cfg.svh"

module ovs_overload_brake #(
  parameter int TICK_CYCLES = `OVS_TICK_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [15:0] outTorquePct,
  input  wire logic [15:0] outCurrentPct,
  input  wire logic [15:0] outFreqDeciHz,
  input  wire logic        accelerating,
  input  wire logic        decelerating,
  input  wire logic        alarmShutdown,
  input  wire logic        runCmd,
  input  wire logic        coast_stop_cmd,
  input  wire logic        motor2Select,
  output logic             brake_release_cmd,
  output logic             overload_stop_alarm,
  output logic             overload_stop_alarm_alt,
  output logic             decelStopReq,
  output logic             outputCutReq,
  output logic             torqueHoldReq,
  output logic             driveLimitIgnore,
  output logic             accelInhibit
);

  ovs_reg_if regs ();

  logic [6:0]  cfg_r;
  logic [15:0] level_r;
  logic [15:0] dwell_r;
  logic [7:0]  relCur_r;
  logic [7:0]  relFrq_r;
  logic [8:0]  relTmr_r;
  logic [7:0]  engFrq_r;
  logic [8:0]  engTmr_r;
  logic [2:0]  syncA_r;
  logic [2:0]  syncB_r;
  logic        runPrev_r;
  logic        runOffSeen_r;
  logic        latched_r;
  ovs_pkg::ovs_mode_t       action_r;
  ovs_pkg::ovs_brk_state_t  brk_r;
  ovs_pkg::ovs_brk_state_t  brk_nxt;
  logic [31:0] tickCnt_r;
  logic        tick;
  logic        runS;
  logic        coastS;
  logic        motor2S;
  ovs_pkg::ovs_mode_t mode;
  ovs_pkg::ovs_qual_t qual;
  logic        useCurrent;
  logic [15:0] drivingTorque;
  logic [15:0] loadIndex;
  logic        stateOk;
  logic        overCond;
  logic        dwellDone;
  logic        trigger;
  logic        shutdown;
  logic        relCond;
  logic        relDone;
  logic        engCond;
  logic        engDone;
  logic [31:0] rdMux;

  // clamp a written setting to its upper limit
  function automatic logic [8:0] clampSet(input logic [8:0] val, input logic [8:0] lim);
    clampSet = (val > lim) ? lim : val;
  endfunction : clampSet

  // bus front end
  ovs_ahb_slave u_bus (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regs      (regs)
  );

  // two-stage synchronisers for pin inputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      syncA_r <= 3'h0;
      syncB_r <= 3'h0;
    end
    else
    begin
      syncA_r <= {motor2Select, coast_stop_cmd, runCmd};
      syncB_r <= syncA_r;
    end
  end

  assign runS    = syncB_r[0];
  assign coastS  = syncB_r[1];
  assign motor2S = syncB_r[2];
  // 10 ms time base for all dwell timers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      tickCnt_r <= 32'h0000_0000;
    else if (tick)
      tickCnt_r <= 32'h0000_0000;
    else
      tickCnt_r <= tickCnt_r + 32'h0000_0001;
  end

  assign tick = (tickCnt_r >= 32'(TICK_CYCLES - 1));
  // configuration register writes
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg_r    <= `OVS_CFG_RST;
      level_r  <= `OVS_LEVEL_RST;
      dwell_r  <= `OVS_DWELL_RST;
      relCur_r <= `OVS_REL_CUR_RST;
      relFrq_r <= `OVS_REL_FRQ_RST;
      relTmr_r <= `OVS_TMR_RST;
      engFrq_r <= `OVS_ENG_FRQ_RST;
      engTmr_r <= `OVS_TMR_RST;
    end
    else if (regs.wrStb)
    begin
      if (regs.wrAddr == `OVS_OFS_CFG)
        cfg_r <= regs.wrData[6:0];
      else if (regs.wrAddr == `OVS_OFS_LEVEL)
        level_r <= regs.wrData[15:0];
      else if (regs.wrAddr == `OVS_OFS_DWELL)
        dwell_r <= regs.wrData[15:0];
      else if (regs.wrAddr == `OVS_OFS_BRK_REL)
      begin
        relCur_r <= 8'(clampSet({1'b0, regs.wrData[`OVS_REL_CUR_LSB +: 8]},
                                {1'b0, `OVS_CUR_MAX}));
        relFrq_r <= 8'(clampSet({1'b0, regs.wrData[`OVS_REL_FRQ_LSB +: 8]},
                                {1'b0, `OVS_FREQ_MAX}));
        relTmr_r <= clampSet(regs.wrData[`OVS_REL_TMR_LSB +: 9], `OVS_TIMER_MAX);
      end
      else if (regs.wrAddr == `OVS_OFS_BRK_ENG)
      begin
        engFrq_r <= 8'(clampSet({1'b0, regs.wrData[`OVS_ENG_FRQ_LSB +: 8]},
                                {1'b0, `OVS_FREQ_MAX}));
        engTmr_r <= clampSet(regs.wrData[`OVS_ENG_TMR_LSB +: 9], `OVS_TIMER_MAX);
      end
    end
  end

  // register read mux, unmapped reads as zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (regs.rdAddr == `OVS_OFS_CFG)
      rdMux = {25'h0, cfg_r};
    else if (regs.rdAddr == `OVS_OFS_LEVEL)
      rdMux = {16'h0, level_r};
    else if (regs.rdAddr == `OVS_OFS_DWELL)
      rdMux = {16'h0, dwell_r};
    else if (regs.rdAddr == `OVS_OFS_BRK_REL)
      rdMux = {7'h0, relTmr_r, relFrq_r, relCur_r};
    else if (regs.rdAddr == `OVS_OFS_BRK_ENG)
      rdMux = {15'h0, engTmr_r, engFrq_r};
    else if (regs.rdAddr == `OVS_OFS_STATUS)
      rdMux = {25'h0, overload_stop_alarm_alt, overload_stop_alarm,
               brake_release_cmd, action_r, runOffSeen_r, latched_r};
  end

  assign regs.rdData = rdMux;
  // decoded configuration fields
  assign useCurrent = cfg_r[`OVS_CFG_LOAD_BIT];
  assign mode       = ovs_pkg::ovs_mode_t'(cfg_r[`OVS_CFG_MODE_LSB +: 2]);
  assign qual       = ovs_pkg::ovs_qual_t'(cfg_r[`OVS_CFG_QUAL_LSB +: 2]);

  // only driving (positive) torque counts
  assign drivingTorque = outTorquePct[15] ? 16'h0000 : outTorquePct;
  // load index: torque in hit-and-stop, else per selector, both in percent
  always_comb
  begin
    if (mode == ovs_pkg::OVS_MODE_HIT)
      loadIndex = drivingTorque;
    else if (useCurrent)
      loadIndex = outCurrentPct;
    else
      loadIndex = drivingTorque;
  end

  // operating-state qualifier
  always_comb
  begin
    case (qual)
      ovs_pkg::OVS_QUAL_CONST_DEC: stateOk = !accelerating;
      ovs_pkg::OVS_QUAL_CONST:     stateOk = !accelerating && !decelerating;
      ovs_pkg::OVS_QUAL_ALL:       stateOk = 1'b1;
      default:                     stateOk = 1'b0;
    endcase
  end

  // detection condition, never armed while stop disabled or latched
  assign overCond = (mode != ovs_pkg::OVS_MODE_OFF) && stateOk && runS &&
                    !latched_r && (loadIndex > level_r);

  // overload dwell timer
  ovs_dwell_timer u_ovl_tmr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (tick),
    .cond    (overCond),
    .preset  (dwell_r),
    .done    (dwellDone)
  );

  // modes 1/2 wait the dwell, mode 3 acts at once
  assign trigger = (mode == ovs_pkg::OVS_MODE_HIT) ? overCond
                                                   : dwellDone;

  // run edge tracking for latch release
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      runPrev_r <= 1'b0;
    else
      runPrev_r <= runS;
  end

  // latched stop state: released by run off then on
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      latched_r    <= 1'b0;
      runOffSeen_r <= 1'b0;
      action_r     <= ovs_pkg::OVS_MODE_OFF;
    end
    else if (trigger)
    begin
      latched_r    <= 1'b1;
      runOffSeen_r <= 1'b0;
      action_r     <= mode;
    end
    else if (latched_r)
    begin
      if (!runS)
        runOffSeen_r <= 1'b1;
      if (runOffSeen_r && runS && !runPrev_r)
      begin
        latched_r    <= 1'b0;
        runOffSeen_r <= 1'b0;
        action_r     <= ovs_pkg::OVS_MODE_OFF;
      end
    end
  end

  // stop action requests to the drive core
  assign decelStopReq  = latched_r && (action_r == ovs_pkg::OVS_MODE_DECEL);
  assign outputCutReq  = latched_r && (action_r == ovs_pkg::OVS_MODE_COAST);
  assign torqueHoldReq = latched_r && (action_r == ovs_pkg::OVS_MODE_HIT) &&
                         runS;
  assign accelInhibit  = latched_r;
  assign driveLimitIgnore = (mode == ovs_pkg::OVS_MODE_HIT);
  // alarm during hit-and-stop, one of two indications
  assign overload_stop_alarm     = torqueHoldReq && !cfg_r[`OVS_CFG_ALT_BIT];
  assign overload_stop_alarm_alt = torqueHoldReq && cfg_r[`OVS_CFG_ALT_BIT];

  // any output shutdown forces the brake on
  assign shutdown = alarmShutdown || coastS || outputCutReq;

  // release: current and frequency above thresholds
  assign relCond = runS && !shutdown && !motor2S &&
                   (outCurrentPct > {8'h00, relCur_r}) &&
                   (outFreqDeciHz > {8'h00, relFrq_r});

  // engage: run off and frequency below threshold
  assign engCond = !runS && (outFreqDeciHz < {8'h00, engFrq_r});
  ovs_dwell_timer u_rel_tmr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (tick),
    .cond    (relCond && (brk_r == ovs_pkg::OVS_BRK_ENGAGED)),
    .preset  ({7'h00, relTmr_r}),
    .done    (relDone)
  );

  ovs_dwell_timer u_eng_tmr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (tick),
    .cond    (engCond && (brk_r == ovs_pkg::OVS_BRK_RELEASED)),
    .preset  ({7'h00, engTmr_r}),
    .done    (engDone)
  );

  // brake command state machine
  always_comb
  begin
    brk_nxt = brk_r;
    case (brk_r)
      ovs_pkg::OVS_BRK_ENGAGED:
      begin
        if (relDone)
          brk_nxt = ovs_pkg::OVS_BRK_RELEASED;
      end
      ovs_pkg::OVS_BRK_RELEASED:
      begin
        if (shutdown || motor2S)
          brk_nxt = ovs_pkg::OVS_BRK_ENGAGED;
        else if (engDone)
          brk_nxt = ovs_pkg::OVS_BRK_ENGAGED;
      end
      default:
        brk_nxt = ovs_pkg::OVS_BRK_ENGAGED;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      brk_r <= ovs_pkg::OVS_BRK_ENGAGED;
    else
      brk_r <= brk_nxt;
  end

  // engaged at once on shutdown or motor 2, without a clock edge
  assign brake_release_cmd = (brk_r == ovs_pkg::OVS_BRK_RELEASED) &&
                             !shutdown && !motor2S;

endmodule : ovs_overload_brake

`default_nettype wire

//--- ovs_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module ovs_motor_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        runCmd,
  input  wire logic        stopRamp,
  input  wire logic        stopCut,
  input  wire logic        brakeRelease,
  input  wire logic [15:0] loadTorque,
  input  wire logic [15:0] loadCurrent,
  input  wire logic [15:0] targetFreq,
  output logic [15:0]      outTorquePct,
  output logic [15:0]      outCurrentPct,
  output logic [15:0]      outFreqDeciHz,
  output logic             accelerating,
  output logic             decelerating,
  output logic             brakeHeld
);
  // pads clamp whenever the release command is absent
  assign brakeHeld = !brakeRelease;
  // a cut output carries no torque and no current
  assign outTorquePct  = stopCut ? 16'h0000 : loadTorque;
  assign outCurrentPct = stopCut ? 16'h0000 : loadCurrent;
  // shaft speed ramps one step a cycle, drops to zero at once on a cut output
  always_ff @(posedge sys_clk)
  begin
    accelerating <= 1'b0;
    decelerating <= 1'b0;
    if (!rst_n || stopCut)
      outFreqDeciHz <= 16'h0000;
    else if (runCmd && !stopRamp && outFreqDeciHz < targetFreq)
    begin
      outFreqDeciHz <= outFreqDeciHz + 16'h0001;
      accelerating  <= 1'b1;
    end
    else if ((!runCmd || stopRamp) && outFreqDeciHz != 16'h0000)
    begin
      outFreqDeciHz <= outFreqDeciHz - 16'h0001;
      decelerating  <= 1'b1;
    end
  end
endmodule : ovs_motor_model
`default_nettype wire

//--- ovs_overload_brake_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ovs_overload_brake_asserts #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic runCmd,
  input wire logic coast_stop_cmd,
  input wire logic motor2Select,
  input wire logic alarmShutdown,
  input wire logic brake_release_cmd,
  input wire logic overload_stop_alarm,
  input wire logic overload_stop_alarm_alt,
  input wire logic decelStopReq,
  input wire logic outputCutReq,
  input wire logic torqueHoldReq,
  input wire logic accelInhibit
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // pin levels held long enough to cross the synchroniser
  sequence runLow3;
    !runCmd [*3];
  endsequence
  sequence coastHigh3;
    coast_stop_cmd [*3];
  endsequence
  sequence motor2High3;
    motor2Select [*3];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  a_motor2_engaged: assert property (motor2High3 |-> !brake_release_cmd)
    else $error("brake released with motor 2");
  a_alarm_engages: assert property (alarmShutdown |-> !brake_release_cmd)
    else $error("brake released during alarm shutdown");
  a_coast_engages: assert property (coastHigh3 |-> !brake_release_cmd)
    else $error("brake released during coast stop");
  a_cut_engages: assert property (outputCutReq |-> !brake_release_cmd)
    else $error("brake released with output cut");
  a_stop_inhibits: assert property
    ((decelStopReq || outputCutReq || torqueHoldReq) |-> accelInhibit)
    else $error("stop request without acceleration inhibit");
  a_hold_alarm: assert property
    (torqueHoldReq |-> (overload_stop_alarm || overload_stop_alarm_alt))
    else $error("torque hold without alarm");
  a_alarm_single: assert property (!(overload_stop_alarm && overload_stop_alarm_alt))
    else $error("both alarms raised");
  a_one_action: assert property ($onehot0({decelStopReq, outputCutReq, torqueHoldReq}))
    else $error("more than one stop action");
  a_run_off_hold: assert property (runLow3 |-> !torqueHoldReq)
    else $error("torque hold kept after run off");
  a_latch_release: assert property
    (($fell(accelInhibit) && $past(rst_n)) |-> $past(runCmd, 2))
    else $error("latch released without run on");
endmodule : ovs_overload_brake_asserts
bind ovs_overload_brake ovs_overload_brake_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
  .runCmd(runCmd), .coast_stop_cmd(coast_stop_cmd), .motor2Select(motor2Select),
  .alarmShutdown(alarmShutdown), .brake_release_cmd(brake_release_cmd),
  .overload_stop_alarm(overload_stop_alarm),
  .overload_stop_alarm_alt(overload_stop_alarm_alt), .decelStopReq(decelStopReq),
  .outputCutReq(outputCutReq), .torqueHoldReq(torqueHoldReq),
  .accelInhibit(accelInhibit));
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk, rst_n, hwrite, accel, decel, alarmShutdown, runCmd, coast;
  logic        motor2Select, brake, alarmA, alarmB, hreadyout, hresp;
  logic        decelStopReq, outputCutReq, torqueHoldReq, driveLimitIgnore, accelInhibit;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [15:0] tq, cu, frq, loadT, loadC, targetFreq;
  int          miscompares, checked, i;
  ovs_overload_brake #(.TICK_CYCLES(4)) u_ovs_overload_brake (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .outTorquePct(tq),
    .outCurrentPct(cu), .outFreqDeciHz(frq), .accelerating(accel), .decelerating(decel),
    .alarmShutdown(alarmShutdown), .runCmd(runCmd), .coast_stop_cmd(coast),
    .motor2Select(motor2Select), .brake_release_cmd(brake), .overload_stop_alarm(alarmA),
    .overload_stop_alarm_alt(alarmB), .decelStopReq(decelStopReq),
    .outputCutReq(outputCutReq), .torqueHoldReq(torqueHoldReq),
    .driveLimitIgnore(driveLimitIgnore), .accelInhibit(accelInhibit));
  ovs_motor_model u_ovs_motor_model (
    .sys_clk(sys_clk), .rst_n(rst_n), .runCmd(runCmd), .stopRamp(decelStopReq),
    .stopCut(outputCutReq), .brakeRelease(brake), .loadTorque(loadT),
    .loadCurrent(loadC), .targetFreq(targetFreq), .outTorquePct(tq),
    .outCurrentPct(cu), .outFreqDeciHz(frq), .accelerating(accel),
    .decelerating(decel), .brakeHeld());
  // free-running system clock
  always #10 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one bus transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : xfer
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h00000000);
    chk(n, e, rdv);
  endtask : rdc
  // restart run with the given setup, apply load, look at the stop outputs
  task automatic ovl(input logic [6:0] c, input logic [15:0] t, input logic [15:0] k,
                     input int n, input logic [6:0] e);
    loadT <= 16'h0000;
    loadC <= 16'h0000;
    runCmd <= 1'b0;
    repeat (10) @(posedge sys_clk);
    xfer(1'b1, 8'h00, {25'h0000000, c});
    runCmd <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 chk("inhibit", 32'h0, {31'h0, accelInhibit});
    @(posedge sys_clk);
    loadT <= t;
    loadC <= k;
    repeat (n) @(posedge sys_clk);
    #1 chk("stop", {25'h0, e}, {25'h0, accelInhibit, decelStopReq, outputCutReq,
                     torqueHoldReq, alarmA, alarmB, driveLimitIgnore});
    @(posedge sys_clk);
  endtask : ovl
  task automatic results;
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    results();
  end
  // main sequence
  initial
  begin
    {sys_clk, rst_n, hwrite, alarmShutdown, runCmd, coast, motor2Select} = 7'h00;
    {htrans, haddr, hwdata, loadT, loadC} = '0;
    targetFreq = 16'd1000;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(8'h00, 32'h00000000, "cfg");
    rdc(8'h04, 32'h00000096, "level");
    rdc(8'h18, 32'h00000000, "unmapped");
    xfer(1'b1, 8'h0c, 32'h01ffffff);
    rdc(8'h0c, 32'h01f4fac8, "rel");
    xfer(1'b1, 8'h10, 32'h0001ffff);
    rdc(8'h10, 32'h0001f4fa, "eng");
    xfer(1'b1, 8'h04, 32'h00000064);
    xfer(1'b1, 8'h08, 32'h0000000a);
    ovl(7'h21, 200, 200, 60, 7'h00);
    ovl(7'h25, 0, 200, 60, 7'h60);
    ovl(7'h29, 0, 200, 60, 7'h50);
    ovl(7'h2d, 200, 50, 6, 7'h4d);
    ovl(7'h2d, 50, 200, 60, 7'h01);
    ovl(7'h6d, 200, 0, 6, 7'h4b);
    ovl(7'h24, 100, 0, 60, 7'h00);
    ovl(7'h24, 101, 0, 60, 7'h60);
    ovl(7'h24, 16'hff00, 0, 60, 7'h00);
    ovl(7'h25, 0, 200, 30, 7'h00);
    loadC <= 16'h0000;
    @(posedge sys_clk);
    loadC <= 16'd200;
    repeat (30) @(posedge sys_clk);
    #1 chk("dwell restart", 32'h0, {31'h0, decelStopReq});
    repeat (20) @(posedge sys_clk);
    #1 chk("dwell done", 32'h1, {31'h0, decelStopReq});
    @(posedge sys_clk);
    rdc(8'h14, 32'h00000005, "status");
    ovl(7'h05, 0, 200, 60, 7'h00);
    ovl(7'h15, 0, 200, 60, 7'h00);
    targetFreq <= 16'd5;
    ovl(7'h15, 0, 200, 60, 7'h60);
    ovl(7'h21, 0, 0, 1, 7'h00);
    xfer(1'b1, 8'h0c, 32'h00033214);
    xfer(1'b1, 8'h10, 32'h0000031e);
    // shaft to rest first, so release must wait for the ramp past the threshold
    runCmd <= 1'b0;
    for (i = 0; i < 1000 && frq !== 16'h0000; i++) @(posedge sys_clk);
    runCmd <= 1'b1;
    loadC <= 16'd100;
    targetFreq <= 16'd300;
    repeat (58) @(posedge sys_clk);
    #1 chk("brake early", 32'h0, {31'h0, brake});
    for (i = 0; i < 100 && brake !== 1'b1; i++) @(posedge sys_clk);
    #1 chk("brake release", 32'h1, {31'h0, brake});
    @(posedge sys_clk);
    motor2Select <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk("brake motor2", 32'h0, {31'h0, brake});
    @(posedge sys_clk);
    motor2Select <= 1'b0;
    alarmShutdown <= 1'b1;
    @(posedge sys_clk);
    #1 chk("brake alarm", 32'h0, {31'h0, brake});
    @(posedge sys_clk);
    alarmShutdown <= 1'b0;
    coast <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk("brake coast", 32'h0, {31'h0, brake});
    @(posedge sys_clk);
    coast <= 1'b0;
    for (i = 0; i < 100 && brake !== 1'b1; i++) @(posedge sys_clk);
    repeat (100) @(posedge sys_clk);
    runCmd <= 1'b0;
    repeat (100) @(posedge sys_clk);
    #1 chk("brake held off", 32'h1, {31'h0, brake});
    for (i = 0; i < 400 && brake !== 1'b0; i++) @(posedge sys_clk);
    #1 chk("brake engage", 32'h0, {31'h0, brake});
    results();
  end
endmodule : tb
`default_nettype wire
